// ===== vdoh_top.sv
// Voltage-code decode, channel current balance and overcurrent hiccup sequencer.
// Notes on behaviour
// [RL1] Sample each active channel once per cycle.
// [RL2] Unused channel samplers stay inactive.
// [RL3] Balance error is average minus channel sample.
// [RL4] Average above trip reference starts shutdown.
// [RL5] Shutdown puts all phase outputs high-impedance.
// [RL6] Hold high-impedance for 2048 phase cycles.
// [RL7] After wait, soft start, then run.
// [RL8] Failed soft start repeats wait, endlessly.
// [RL9] Decode code to 1100 mV plus 25 mV steps.
// [RL10] All-ones code shuts down; others restart.
// [RL11] Phase clock marks one switching cycle.
// [RL12] Trip during soft start fails; wait restarts.
module vdoh_top
    import vdoh_pkg::*;
(
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         enable_i,
    input  wire logic                         three_phase_i,
    input  wire logic                         phase_tick_i,
    input  wire logic [4:0]                   voltage_select_code_i,
    input  wire logic [CUR_W-1:0]             channel_current_sense_i [N_CH],
    output logic      [LVL_W-1:0]             reference_level_o,
    output logic                              reference_off_o,
    output logic      [CUR_W-1:0]             average_channel_current_o,
    output logic signed [CUR_W:0]             balance_error_o [N_CH],
    output logic      [N_CH-1:0]              phase_output_enable_o,
    output logic                              regulating_o,
    output logic                              overcurrent_o
);
    import vdoh_pkg::*;

    vdoh_state_t           state_q;
    logic [CNT_W-1:0]      cnt_q;
    logic [CUR_W-1:0]      samp [N_CH];
    logic [CUR_W-1:0]      avg_d;
    logic [N_CH-1:0]       act;
    logic                  trip;
    logic                  code_off;

    assign act      = {three_phase_i, 2'b11};
    assign code_off = (voltage_select_code_i == CODE_OFF);

    always_comb begin
        logic [CUR_W+1:0] sum;
        sum = {2'b00, samp[0]} + {2'b00, samp[1]} + (three_phase_i ? {2'b00, samp[2]} : '0);
        if (three_phase_i) begin
            avg_d = CUR_W'(sum / N_CH); // [RL3]
        end else begin
            avg_d = sum[CUR_W:1]; // [RL3]
        end
    end

    assign trip = (average_channel_current_o > TRIP_UA); // [RL4]

    genvar g;
    generate
        for (g = 0; g < N_CH; g++) begin : g_ch
            vdoh_chan u_chan (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .active_i (act[g]),
                .sample_i (phase_tick_i),
                .sense_i  (channel_current_sense_i[g]),
                .avg_i    (average_channel_current_o),
                .sample_o (samp[g]),
                .error_o  (balance_error_o[g])
            );
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            average_channel_current_o <= '0;
        end else begin
            average_channel_current_o <= avg_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reference_level_o <= '0;
            reference_off_o   <= 1'b1;
        end else begin
            reference_off_o   <= code_off; // [RL10]
            reference_level_o <= code_off ? '0 :
                LVL_BASE_MV + LVL_W'((CODE_MAX_LVL - voltage_select_code_i) * LVL_STEP_MV); // [RL9]
        end
    end

    // Counters only advance on the phase tick, one per switching cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i || !enable_i || code_off) begin
            state_q <= VDOH_OFF; // [RL10]
            cnt_q   <= CNT_ZERO;
        end else begin
            case (state_q)
                VDOH_OFF: begin
                    state_q <= VDOH_SOFT;
                    cnt_q   <= CNT_ZERO;
                end
                VDOH_SOFT: begin
                    if (trip) begin
                        state_q <= VDOH_WAIT; // [RL8] [RL12]
                        cnt_q   <= CNT_ZERO;
                    end else if (phase_tick_i) begin // [RL11]
                        if (cnt_q == SOFT_CYC - CNT_ONE) begin
                            state_q <= VDOH_RUN; // [RL7]
                        end
                        cnt_q <= cnt_q + CNT_ONE;
                    end
                end
                VDOH_RUN: begin
                    if (trip) begin
                        state_q <= VDOH_WAIT; // [RL4]
                        cnt_q   <= CNT_ZERO;
                    end
                end
                VDOH_WAIT: begin
                    if (phase_tick_i) begin
                        if (cnt_q == HICCUP_CYC - CNT_ONE) begin
                            state_q <= VDOH_SOFT; // [RL6] [RL7]
                            cnt_q   <= CNT_ZERO;
                        end else begin
                            cnt_q <= cnt_q + CNT_ONE; // [RL6]
                        end
                    end
                end
                default: begin
                    state_q <= VDOH_OFF;
                    cnt_q   <= CNT_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_output_enable_o <= PWM_HIZ;
            regulating_o          <= 1'b0;
            overcurrent_o         <= 1'b0;
        end else begin
            if ((state_q == VDOH_RUN || state_q == VDOH_SOFT) && !trip && enable_i && !code_off) begin
                phase_output_enable_o <= PWM_DRIVE & act;
            end else begin
                phase_output_enable_o <= PWM_HIZ; // [RL5]
            end
            regulating_o  <= (state_q == VDOH_RUN);
            overcurrent_o <= (state_q == VDOH_WAIT);
        end
    end

    sequence s_trip_in_run;
        state_q == VDOH_RUN && trip && enable_i && !code_off;
    endsequence

    a_trip_to_wait: assert property (@(posedge clk_i) disable iff (rst_i) // [RL4]
        s_trip_in_run |=> state_q == VDOH_WAIT) else $error("Trip did not start shutdown.");
    a_trip_hiz: assert property (@(posedge clk_i) disable iff (rst_i) // [RL5]
        trip |=> phase_output_enable_o == PWM_HIZ) else $error("Outputs driven after trip.");
    a_wait_hiz: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
        state_q == VDOH_WAIT |=> phase_output_enable_o == PWM_HIZ) else $error("Outputs driven in wait.");
    a_wait_exit: assert property (@(posedge clk_i) disable iff (rst_i) // [RL7]
        state_q == VDOH_WAIT && phase_tick_i && cnt_q == HICCUP_CYC - CNT_ONE && enable_i && !code_off
        |=> state_q == VDOH_SOFT) else $error("Wait did not end in soft start.");
    a_wait_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
        state_q == VDOH_WAIT && $past(state_q) != VDOH_WAIT |-> cnt_q == CNT_ZERO)
        else $error("Wait count not restarted.");
    a_soft_fail: assert property (@(posedge clk_i) disable iff (rst_i) // [RL8]
        state_q == VDOH_SOFT && trip && enable_i && !code_off |=> state_q == VDOH_WAIT)
        else $error("Failed soft start not retried.");
    a_off_code: assert property (@(posedge clk_i) disable iff (rst_i) // [RL10]
        code_off |=> state_q == VDOH_OFF ##1 phase_output_enable_o == PWM_HIZ)
        else $error("Off code did not shut down.");
    a_level_decode: assert property (@(posedge clk_i) disable iff (rst_i) // [RL9]
        voltage_select_code_i == 5'h00 |=> reference_level_o == 11'h73a) else $error("Top code level wrong.");
    sequence s_soft_done;
        state_q == VDOH_SOFT && !trip && phase_tick_i && cnt_q == SOFT_CYC - CNT_ONE && enable_i && !code_off;
    endsequence

    sequence s_wait_step;
        state_q == VDOH_WAIT && phase_tick_i && cnt_q != HICCUP_CYC - CNT_ONE && enable_i && !code_off;
    endsequence

    sequence s_enabled_off;
        state_q == VDOH_OFF && enable_i && !code_off;
    endsequence

    a_soft_to_run: assert property (@(posedge clk_i) disable iff (rst_i) // [RL7]
        s_soft_done |=> state_q == VDOH_RUN)
        else $error("Soft start did not end in run.");
    a_wait_count: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
        s_wait_step |=> state_q == VDOH_WAIT && cnt_q == $past(cnt_q) + CNT_ONE)
        else $error("Wait count did not step.");
    a_off_restart: assert property (@(posedge clk_i) disable iff (rst_i) // [RL10]
        s_enabled_off |=> state_q == VDOH_SOFT)
        else $error("Valid code did not restart.");
    a_oc_flag: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
        state_q == VDOH_WAIT |=> overcurrent_o)
        else $error("Overcurrent flag missing in wait.");
    a_run_flag: assert property (@(posedge clk_i) disable iff (rst_i) // [RL7]
        state_q == VDOH_RUN |=> regulating_o)
        else $error("Run flag missing in run.");
    a_off_hiz: assert property (@(posedge clk_i) disable iff (rst_i) // [RL5]
        state_q == VDOH_OFF |=> phase_output_enable_o == PWM_HIZ)
        else $error("Outputs driven while off.");
    a_avg_form: assert property (@(posedge clk_i) disable iff (rst_i) // [RL3]
        1'b1 |=> average_channel_current_o == $past(avg_d))
        else $error("Average not registered.");
    a_unused_err: assert property (@(posedge clk_i) disable iff (rst_i) // [RL2]
        !three_phase_i |=> balance_error_o[N_CH-1] == '0)
        else $error("Unused channel error not idle.");
    a_unused_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [RL2]
        !three_phase_i |=> samp[2] == '0) else $error("Unused channel sampled.");
    a_sample_take: assert property (@(posedge clk_i) disable iff (rst_i) // [RL1]
        phase_tick_i |=> samp[0] == $past(channel_current_sense_i[0])) else $error("Sample not taken.");
endmodule

// ===== vdoh_pkg.sv
// Package with constants and types for the voltage-code decode and overcurrent hiccup block.
package vdoh_pkg;
    localparam int          CUR_W         = 12;
    localparam int          LVL_W         = 11;
    localparam int          CNT_W         = 12;
    localparam int          N_CH          = 3;
    localparam logic [4:0]  CODE_OFF      = 5'h1f;
    localparam logic [4:0]  CODE_MAX_LVL  = 5'h1e;
    localparam logic [10:0] LVL_BASE_MV   = 11'h44c;
    localparam logic [10:0] LVL_STEP_MV   = 11'h019;
    localparam logic [11:0] TRIP_UA       = 12'h04b;
    localparam logic [11:0] HICCUP_CYC    = 12'h800;
    localparam logic [11:0] SOFT_CYC      = 12'h800;
    localparam logic [2:0]  PWM_HIZ       = 3'h0;
    localparam logic [2:0]  PWM_DRIVE     = 3'h7;
    localparam logic [11:0] CNT_ZERO      = 12'h000;
    localparam logic [11:0] CNT_ONE       = 12'h001;
    typedef enum logic [1:0] {VDOH_OFF, VDOH_WAIT, VDOH_SOFT, VDOH_RUN} vdoh_state_t;
endpackage

// ===== vdoh_chan.sv
// One channel's current sampler and balance error.
module vdoh_chan
    import vdoh_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                active_i,
    input  wire logic                sample_i,
    input  wire logic [CUR_W-1:0]    sense_i,
    input  wire logic [CUR_W-1:0]    avg_i,
    output logic      [CUR_W-1:0]    sample_o,
    output logic signed [CUR_W:0]    error_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i || !active_i) begin
            sample_o <= '0; // [RL2]
        end else if (sample_i) begin
            sample_o <= sense_i; // [RL1]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !active_i) begin
            error_o <= '0; // [RL2]
        end else begin
            error_o <= $signed({1'b0, avg_i}) - $signed({1'b0, sample_o}); // [RL3]
        end
    end
endmodule

// ===== vdoh_partner.sv
// Far-side model: phase clock source and settled channel current sense lines.
module vdoh_partner
    import vdoh_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [CUR_W-1:0] load_i [N_CH],
    output logic                  phase_tick_o,
    output logic      [CUR_W-1:0] sense_o [N_CH]
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_q;
    always_ff @(posedge clk_i) begin
        div_q        <= rst_i ? 2'h0 : div_q + 2'h1;
        phase_tick_o <= !rst_i && div_q == 2'h3;
    end
    assign sense_o = load_i;
endmodule

// ===== testbench.sv
// Self-checking bench for the voltage-code decode and overcurrent hiccup block.
module testbench;
    import vdoh_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk_i = 1'b0, rst_i = 1'b1, en = 1'b0, three = 1'b1, tick, off, run, oc;
    logic [4:0]            code = 5'h1f;
    logic [CUR_W-1:0]      load [N_CH] = '{default: 12'h014};
    logic [CUR_W-1:0]      sense [N_CH];
    logic [CUR_W-1:0]      avg;
    logic [LVL_W-1:0]      level;
    logic signed [CUR_W:0] err [N_CH];
    logic [N_CH-1:0]       oe;
    int                    errors = 0, n_tests = 0, n;
    always #2.5 clk_i = ~clk_i;
    vdoh_partner vdoh_partner_i (.clk_i(clk_i), .rst_i(rst_i), .load_i(load), .phase_tick_o(tick), .sense_o(sense));
    vdoh_top vdoh_top_i (.clk_i(clk_i), .rst_i(rst_i), .enable_i(en), .three_phase_i(three), .phase_tick_i(tick),
        .voltage_select_code_i(code), .channel_current_sense_i(sense), .reference_level_o(level),
        .reference_off_o(off), .average_channel_current_o(avg), .balance_error_o(err),
        .phase_output_enable_o(oe), .regulating_o(run), .overcurrent_o(oc));
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s exp %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic ticks(int k);
        repeat (k) @(posedge clk_i iff tick);
        @(posedge clk_i);
    endtask
    task automatic wait_count();
        n = 0;
        while (oc !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        n = 0;
        while (oc === 1'b1 && n < 2200) begin
            @(posedge clk_i);
            if (tick) n++;
        end
    endtask
    task automatic t_decode();
        for (int c = 0; c < 32; c++) begin
            code <= 5'(c);
            repeat (3) @(posedge clk_i);
            check("level", 16'(level), (c == 31) ? 16'h0 : 16'(1100 + 25 * (30 - c)));
            check("off", 16'(off), 16'(c == 31));
        end
        $display("t_decode done");
    endtask
    task automatic t_start_balance();
        code <= 5'h10;
        en   <= 1'b1;
        ticks(3);
        check("soft oe", 16'(oe), 16'h7);
        ticks(2050);
        check("run", 16'(run), 16'h1);
        load <= '{12'h01e, 12'h028, 12'h032};
        ticks(3);
        check("avg3", 16'(avg), 16'h028);
        check("err0", 16'(err[0]), 16'h000a);
        check("err2", 16'(err[2]), 16'hfff6);
        three <= 1'b0;
        load  <= '{12'h01e, 12'h032, 12'h063};
        ticks(3);
        check("avg2", 16'(avg), 16'h028);
        check("err2 idle", 16'(err[2]), 16'h0);
        check("oe two", 16'(oe), 16'h3);
        three <= 1'b1;
        $display("t_start_balance done");
    endtask
    task automatic t_hiccup();
        load <= '{default: 12'h04b};
        ticks(3);
        check("no trip", 16'(oc), 16'h0);
        load <= '{default: 12'h04c};
        ticks(2);
        check("trip", 16'(oc), 16'h1);
        check("hiz", 16'(oe), 16'h0);
        wait_count();
        check("wait1", 16'(n >= 2046 && n <= 2049), 16'h1);
        @(posedge clk_i);
        check("retrip", 16'(oc), 16'h1);
        check("retrip hiz", 16'(oe), 16'h0);
        load <= '{default: 12'h014};
        wait_count();
        check("wait2", 16'(n >= 2046 && n <= 2049), 16'h1);
        ticks(1);
        check("retry oe", 16'(oe), 16'h7);
        ticks(2050);
        check("recover", 16'(run), 16'h1);
        $display("t_hiccup done");
    endtask
    task automatic t_off();
        code <= 5'h1f;
        ticks(2);
        check("off oe", 16'(oe), 16'h0);
        code <= 5'h10;
        ticks(2);
        check("on oe", 16'(oe), 16'h7);
        en <= 1'b0;
        ticks(2);
        check("dis oe", 16'(oe), 16'h0);
        $display("t_off done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_decode();
        t_start_balance();
        t_hiccup();
        t_off();
        complete_run();
    end
    initial begin
        #300000;
        errors++;
        complete_run();
    end
endmodule
